// ---- rtl/acvc_pkg.sv ----
// Package with offsets, field positions, reset values and timing constants.
package acvc_pkg;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_RES_ONE = 8'h01;
  localparam logic [7:0] OFS_SETA_ONE = 8'h02;
  localparam logic [7:0] OFS_SETB_ONE = 8'h03;
  localparam logic [7:0] OFS_RES_TWO = 8'h04;
  localparam logic [7:0] OFS_SETA_TWO = 8'h05;
  localparam logic [7:0] OFS_SETB_TWO = 8'h06;
  localparam logic [7:0] OFS_RES_TEMP = 8'h07;
  localparam logic [7:0] OFS_SETA_TEMP = 8'h08;
  localparam logic [7:0] OFS_SETB_TEMP = 8'h09;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_SETB = 16'h0070;
  localparam logic [15:0] MASK_CONTROL = 16'h0F07;
  localparam logic [15:0] MASK_SETA = 16'hFF7F;
  localparam logic [15:0] MASK_SETB = 16'h0073;
  localparam logic [15:0] MASK_SETB_TEMP = 16'h0070;
  localparam int BIT_START_ONE = 2;
  localparam int BIT_START_TWO = 1;
  localparam int BIT_START_TEMP = 0;
  localparam int SEL_LSB = 8;
  localparam int GAIN_LSB = 11;
  localparam int CLK_LSB = 8;
  localparam int RES_LSB = 4;
  localparam int BIAS_LSB = 4;
  localparam int CTL_GO = 15;
  localparam int CTL_READ = 14;
  localparam logic [4:0] GAIN_FIXED_LOW = 5'h1F;
  localparam logic [3:0] SEL_DIFF = 4'h0;
  localparam logic [3:0] SEL_FIXED_LO = 4'h4;
  localparam logic [3:0] SEL_FIXED_HI = 4'h7;
  // Device clock is 4 MHz; the block clock is 100 MHz.
  localparam int CLK_MHZ = 100;
  localparam int DEV_CLK_MHZ = 4;
  localparam int DEV_TICK = CLK_MHZ / DEV_CLK_MHZ;
  localparam int BASE_DIV = 4;
  typedef enum logic [1:0] {ACVC_IDLE, ACVC_CONV} acvc_state_e;
endpackage

// ---- rtl/acvc_clkdiv.sv ----
// ADC sample clock tick generator from the conversion clock code.
`timescale 1ns/1ps
module acvc_clkdiv
  import acvc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [2:0] code,
  output logic            tick
);
  logic [4:0]  pre_reg;
  logic [4:0]  pre_next;
  logic [8:0]  div_reg;
  logic [8:0]  div_next;
  logic [9:0]  div_len;
  wire         dev_tick = (pre_reg == 5'(DEV_TICK - 1));

  assign div_len  = 10'(BASE_DIV) << code;
  // Idle holds the prescaler at one, so the first period is one cycle short
  // and the registered tick still ends a conversion on its exact count.
  assign pre_next = !run ? 5'h01 : dev_tick ? 5'h00 : pre_reg + 5'h01;
  assign div_next = (!run) ? 9'h000 :
                    !dev_tick ? div_reg :
                    (10'(div_reg) == div_len - 10'h001) ? 9'h000 :
                    div_reg + 9'h001;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 5'h01;
      div_reg <= 9'h000;
      tick    <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      div_reg <= div_next;
      tick    <= run && dev_tick && (10'(div_reg) == div_len - 10'h001);
    end
  end
endmodule

// ---- rtl/acvc_len.sv ----
// Conversion length in ADC clocks from the resolution code.
`timescale 1ns/1ps
module acvc_len
  import acvc_pkg::*;
(
  input  wire logic [2:0]  code,
  output logic      [11:0] len
);
  // Code 111 is undefined; it is treated as the longest setting.
  always_comb begin
    case (code)
      3'h0:    len = 12'h100;
      3'h1:    len = 12'h140;
      3'h2:    len = 12'h200;
      3'h3:    len = 12'h280;
      3'h4:    len = 12'h320;
      3'h5:    len = 12'h500;
      default: len = 12'h800;
    endcase
  end
endmodule

// ---- rtl/acvc_top.sv ----
// Conversion control register bank and sequencer for the sensor ADC.
// Operation
// - Control at 00h, most registers reset zero.
// - B-set setup registers reset to 0070h.
// - Selector in bits 11-8, start bits 2-0, others unused.
// - Bit 2 starts channel-one conversion.
// - Processor stalled while conversion runs.
// - Start bits self-clear when conversion completes.
// - Channel one beats two beats temperature.
// - Selector zero converts the differential pair.
// - Temperature converts only with selector zero.
// - Nonzero selector converts chosen single-ended source.
// - Codes 1-7 route internal sources in order.
// - Codes 8 and 9 pick input pins.
// - Codes 4-7 force gain 0.7.
// - Setup A holds gain, clock, resolution.
// - Setup A holds coarse offset sign, magnitude.
// - Setup B holds bias and reference; temperature Setup B holds bias only.
// - Indirect access via address, data, control ports.
// - Results read-only, others read-write.
// - Clock code divides device clock 4..512.
// - Resolution code sets conversion length.
`timescale 1ns/1ps
module acvc_top
  import acvc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic [15:0] MODULE_DATA_PORT,
  input  wire logic [15:0] MODULE_ADDRESS_PORT,
  input  wire logic [15:0] MODULE_CONTROL_PORT,
  input  wire logic [15:0] SAMPLE_RESULT,
  output logic      [15:0] READ_DATA,
  output logic             READ_VALID,
  output logic             ACCESS_DONE,
  output logic             CPU_HALT,
  output logic             CONVERTING,
  output logic      [1:0]  ACTIVE_SOURCE,
  output logic      [3:0]  SINGLE_END_SOURCE_SEL,
  output logic      [4:0]  GAIN_CODE,
  output logic             GAIN_FIXED,
  output logic      [2:0]  RESOLUTION_CODE,
  output logic      [3:0]  COARSE_OFFSET,
  output logic      [2:0]  BIAS_CODE,
  output logic      [1:0]  REFERENCE_SEL
);
  logic [15:0] ctl_reg;
  logic [15:0] ctl_next;
  logic [15:0] res_reg  [3];
  logic [15:0] seta_reg [3];
  logic [15:0] setb_reg [3];
  acvc_state_e state_reg;
  acvc_state_e state_next;
  logic [1:0]  src_reg;
  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;
  logic [11:0] conv_len;
  logic        adc_tick;
  logic        go_seen_reg;

  default clocking acvc_cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  // Transfer taken once per rising edge of the go bit.
  wire        go_edge = MODULE_CONTROL_PORT[CTL_GO] && !go_seen_reg;
  wire        is_rd   = MODULE_CONTROL_PORT[CTL_READ];
  wire [7:0]  addr    = MODULE_ADDRESS_PORT[7:0];
  wire        wr      = go_edge && !is_rd && (state_reg == ACVC_IDLE);
  wire        rd      = go_edge && is_rd;
  wire [3:0]  sel     = ctl_reg[SEL_LSB +: 4];
  wire        want1   = ctl_reg[BIT_START_ONE];
  wire        want2   = ctl_reg[BIT_START_TWO];
  wire        wantt   = ctl_reg[BIT_START_TEMP] && (sel == SEL_DIFF);
  // Priority: channel one, channel two, then temperature.
  wire [1:0]  pick    = want1 ? 2'd0 : want2 ? 2'd1 : 2'd2;
  wire        launch  = (state_reg == ACVC_IDLE) && (want1 || want2 || wantt);
  wire        ctl_wr  = wr && (addr == OFS_CONTROL);
  wire        tskip   = (state_reg == ACVC_IDLE) && !want1 && !want2 &&
                        ctl_reg[BIT_START_TEMP] && !wantt;
  wire [15:0] cfga    = seta_reg[src_reg];
  wire [15:0] cfgb    = setb_reg[src_reg];
  wire        finish  = (state_reg == ACVC_CONV) && adc_tick &&
                        (cnt_reg == conv_len - 12'h001);
  wire        fixed   = (sel >= SEL_FIXED_LO) && (sel <= SEL_FIXED_HI) &&
                        (src_reg != 2'd2);
  wire [15:0] rd_mux  =
      addr == OFS_CONTROL   ? ctl_reg :
      addr == OFS_RES_ONE   ? res_reg[0] :
      addr == OFS_SETA_ONE  ? seta_reg[0] :
      addr == OFS_SETB_ONE  ? setb_reg[0] :
      addr == OFS_RES_TWO   ? res_reg[1] :
      addr == OFS_SETA_TWO  ? seta_reg[1] :
      addr == OFS_SETB_TWO  ? setb_reg[1] :
      addr == OFS_RES_TEMP  ? res_reg[2] :
      addr == OFS_SETA_TEMP ? seta_reg[2] :
      addr == OFS_SETB_TEMP ? setb_reg[2] : RST_ZERO;

  // Lower start bits are dropped when the higher-priority conversion finishes.
  always_comb begin
    ctl_next = ctl_reg;
    if (ctl_wr) begin
      ctl_next = MODULE_DATA_PORT & MASK_CONTROL;
    end
    if (finish) begin
      ctl_next[2:0] = 3'b000;
    end else if (tskip && !ctl_wr) begin
      // A fresh control write wins; its start bits are judged next cycle.
      ctl_next[BIT_START_TEMP] = 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ACVC_IDLE: begin
        cnt_next = 12'h000;
        if (launch) begin
          state_next = ACVC_CONV;
        end
      end
      ACVC_CONV: begin
        if (finish) begin
          state_next = ACVC_IDLE;
        end else if (adc_tick) begin
          cnt_next = cnt_reg + 12'h001;
        end
      end
      default: state_next = ACVC_IDLE;
    endcase
  end

  acvc_clkdiv u_div (
    .clk   (CLK),
    .rst_n (RESETN),
    .run   (state_reg == ACVC_CONV),
    .code  (cfga[CLK_LSB +: 3]),
    .tick  (adc_tick)
  );

  acvc_len u_len (
    .code (cfga[RES_LSB +: 3]),
    .len  (conv_len)
  );

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctl_reg     <= RST_ZERO;
      state_reg   <= ACVC_IDLE;
      src_reg     <= 2'd0;
      cnt_reg     <= 12'h000;
      go_seen_reg <= 1'b0;
    end else begin
      ctl_reg     <= ctl_next;
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      go_seen_reg <= MODULE_CONTROL_PORT[CTL_GO];
      if (launch) begin
        src_reg <= pick;
      end
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_src
    localparam logic [7:0] BASE = 8'(3 * i + 1);
    wire [15:0] bmask = (i == 2) ? MASK_SETB_TEMP : MASK_SETB;
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        res_reg[i]  <= RST_ZERO;
        seta_reg[i] <= RST_ZERO;
        setb_reg[i] <= RST_SETB;
      end else begin
        if (finish && src_reg == 2'(i)) begin
          res_reg[i] <= SAMPLE_RESULT;
        end
        if (wr && addr == BASE + 8'h01) begin
          seta_reg[i] <= MODULE_DATA_PORT & MASK_SETA;
        end
        if (wr && addr == BASE + 8'h02) begin
          setb_reg[i] <= MODULE_DATA_PORT & bmask;
        end
      end
    end
  end

  // Result registers have no processor write path; only a finishing conversion loads them.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      READ_DATA             <= RST_ZERO;
      READ_VALID            <= 1'b0;
      ACCESS_DONE           <= 1'b0;
      CPU_HALT              <= 1'b0;
      CONVERTING            <= 1'b0;
      ACTIVE_SOURCE         <= 2'd0;
      SINGLE_END_SOURCE_SEL <= 4'h0;
      GAIN_CODE             <= 5'h00;
      GAIN_FIXED            <= 1'b0;
      RESOLUTION_CODE       <= 3'h0;
      COARSE_OFFSET         <= 4'h0;
      BIAS_CODE             <= 3'h0;
      REFERENCE_SEL         <= 2'h0;
    end else begin
      READ_VALID  <= rd;
      ACCESS_DONE <= go_edge && (is_rd || state_reg == ACVC_IDLE);
      if (rd) begin
        READ_DATA <= rd_mux;
      end
      CPU_HALT   <= (state_next == ACVC_CONV);
      CONVERTING <= (state_next == ACVC_CONV);
      ACTIVE_SOURCE <= launch ? pick : src_reg;
      SINGLE_END_SOURCE_SEL <= (src_reg == 2'd2) ? SEL_DIFF : sel;
      GAIN_CODE  <= fixed ? GAIN_FIXED_LOW : cfga[GAIN_LSB +: 5];
      GAIN_FIXED <= fixed;
      RESOLUTION_CODE <= cfga[RES_LSB +: 3];
      COARSE_OFFSET   <= cfga[3:0];
      BIAS_CODE       <= cfgb[BIAS_LSB +: 3];
      REFERENCE_SEL   <= cfgb[1:0];
    end
  end

  // Assertions take the default clock and reset; covers name their clock.
  a_halt_tracks_conv: assert property (
    (state_reg == ACVC_CONV) |-> CPU_HALT)
    else $error("processor not halted during conversion");
  a_launch_halts: assert property (
    launch |=> CPU_HALT && CONVERTING)
    else $error("processor not halted at launch");
  a_halt_release: assert property (
    finish |=> !CPU_HALT && !CONVERTING)
    else $error("processor still halted after conversion");
  a_start_self_clear: assert property (
    finish |=> ctl_reg[2:0] == 3'b000)
    else $error("start bits not cleared");
  a_priority_one: assert property (
    (launch && want1) |=> src_reg == 2'd0)
    else $error("channel one lost priority");
  a_priority_two: assert property (
    (launch && !want1 && want2) |=> src_reg == 2'd1)
    else $error("channel two lost priority");
  a_temp_needs_zero: assert property (
    (launch && !want1 && !want2) |-> sel == SEL_DIFF)
    else $error("temperature launched with nonzero selector");
  a_temp_refused: assert property (
    tskip |=> state_reg == ACVC_IDLE)
    else $error("temperature converted with nonzero selector");
  a_temp_dropped: assert property (
    (tskip && !ctl_wr) |=> !ctl_reg[BIT_START_TEMP])
    else $error("refused temperature start not cleared");
  a_temp_sel_zero: assert property (
    (state_reg == ACVC_CONV && src_reg == 2'd2) |-> sel == SEL_DIFF)
    else $error("selector changed during temperature conversion");
  a_result_capture: assert property (
    (finish && src_reg == 2'd0) |=> res_reg[0] == $past(SAMPLE_RESULT))
    else $error("channel one result not stored");
  a_two_capture: assert property (
    (finish && src_reg == 2'd1) |=> res_reg[1] == $past(SAMPLE_RESULT))
    else $error("channel two result not stored");
  a_temp_capture: assert property (
    (finish && src_reg == 2'd2) |=> res_reg[2] == $past(SAMPLE_RESULT))
    else $error("temperature result not stored");
  a_result_hold: assert property (
    (state_reg == ACVC_IDLE) |=> $stable(res_reg[0]) && $stable(res_reg[1])
      && $stable(res_reg[2]))
    else $error("result changed outside a conversion");
  a_unused_zero: assert property (
    (ctl_reg & ~MASK_CONTROL) == RST_ZERO)
    else $error("unused control bits set");
  a_setup_unused: assert property (
    ((seta_reg[0] & ~MASK_SETA) == RST_ZERO) &&
    ((setb_reg[2] & ~MASK_SETB_TEMP) == RST_ZERO))
    else $error("unused setup bits set");
  a_gain_forced: assert property (
    fixed |=> GAIN_CODE == GAIN_FIXED_LOW)
    else $error("gain not forced");
  a_gain_free: assert property (
    (state_reg == ACVC_CONV && !fixed) |=>
      GAIN_CODE == $past(cfga[GAIN_LSB +: 5]))
    else $error("configured gain not routed");
  a_sel_routed: assert property (
    (state_reg == ACVC_CONV && src_reg != 2'd2) |=>
      SINGLE_END_SOURCE_SEL == $past(sel))
    else $error("selector not routed");
  a_bias_routed: assert property (
    (state_reg == ACVC_CONV) |=> BIAS_CODE == $past(cfgb[BIAS_LSB +: 3])
      && REFERENCE_SEL == $past(cfgb[1:0]))
    else $error("bias or reference not routed");
  a_count_bound: assert property (
    (state_reg == ACVC_CONV) |-> cnt_reg < conv_len)
    else $error("conversion ran past its length");
  a_write_refused: assert property (
    (go_edge && !is_rd && state_reg == ACVC_CONV) |=> !ACCESS_DONE)
    else $error("write accepted during conversion");
  a_access_pulse: assert property (
    ACCESS_DONE |=> !ACCESS_DONE && !READ_VALID)
    else $error("transfer answer longer than one cycle");
  a_read_answer: assert property (
    rd |=> READ_VALID && READ_DATA == $past(rd_mux))
    else $error("read answer wrong");

  c_conv_one: cover property (@(posedge CLK) finish && src_reg == 2'd0);
  c_conv_two: cover property (@(posedge CLK) finish && src_reg == 2'd1);
  c_conv_temp: cover property (@(posedge CLK) finish && src_reg == 2'd2);
  c_read: cover property (@(posedge CLK) rd);
  c_temp_skip: cover property (@(posedge CLK) tskip);
endmodule

// ---- sim/acvc_cpu_model.sv ----
// Processor side model driving the indirect module ports.
`timescale 1ns/1ps
module acvc_cpu_model
  import acvc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        halt,
  input  wire logic        done,
  input  wire logic        rvalid,
  input  wire logic [15:0] rdata,
  output logic      [15:0] dport,
  output logic      [15:0] aport,
  output logic      [15:0] cport
);
  initial begin
    dport = 16'h0000;
    aport = 16'h0000;
    cport = 16'h0000;
  end
  // A halted processor issues nothing, so a transfer waits out a conversion.
  task automatic xfer(input logic r, input logic [7:0] a,
                      input logic [15:0] d, output logic [15:0] q,
                      output logic ok);
    int n;
    ok = 1'b0;
    q = 16'h0000;
    for (n = 0; n < 40000 && halt === 1'b1; n++) @(negedge clk);
    @(negedge clk);
    aport <= {8'h00, a};
    dport <= d;
    cport <= {1'b1, r, 14'h0000};
    for (n = 0; n < 8 && !ok; n++) begin
      // The answer launched at one edge is taken at the next, go still high.
      @(posedge clk);
      if (done === 1'b1 || rvalid === 1'b1) begin
        ok = 1'b1;
        q = rdata;
      end
    end
    @(negedge clk);
    cport <= 16'h0000;
  endtask
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the conversion control register bank.
`timescale 1ns/1ps
module tb
  import acvc_pkg::*;
;
  logic        clk, resetn;
  logic [15:0] dp, ap, cp, smp, rdd, seed;
  logic        rv, dn, halt, conv_o, gfix;
  logic [1:0]  src, refs;
  logic [3:0]  sel, coff;
  logic [4:0]  gain;
  logic [2:0]  resc, bias;
  logic [15:0] mdl [0:9];
  int          fail_count, checks_done, cyc;

  acvc_top acvc_top_inst (
    .CLK(clk), .RESETN(resetn), .MODULE_DATA_PORT(dp),
    .MODULE_ADDRESS_PORT(ap), .MODULE_CONTROL_PORT(cp),
    .SAMPLE_RESULT(smp), .READ_DATA(rdd), .READ_VALID(rv),
    .ACCESS_DONE(dn), .CPU_HALT(halt), .CONVERTING(conv_o),
    .ACTIVE_SOURCE(src), .SINGLE_END_SOURCE_SEL(sel), .GAIN_CODE(gain),
    .GAIN_FIXED(gfix), .RESOLUTION_CODE(resc), .COARSE_OFFSET(coff),
    .BIAS_CODE(bias), .REFERENCE_SEL(refs));
  acvc_cpu_model acvc_cpu_model_inst (
    .clk(clk), .halt(halt), .done(dn), .rvalid(rv), .rdata(rdd),
    .dport(dp), .aport(ap), .cport(cp));

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] msk(input int a);
    case (a)
      0: return MASK_CONTROL;
      2, 5, 8: return MASK_SETA;
      3, 6: return MASK_SETB;
      9: return MASK_SETB_TEMP;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input int a, input logic [15:0] d);
    logic [15:0] q;
    logic        ok;
    acvc_cpu_model_inst.xfer(1'b0, a[7:0], d, q, ok);
    chk(16'(ok), 16'h0001);
    if (msk(a) != 16'h0000) mdl[a] = d & msk(a);
  endtask
  task automatic rd(input int a);
    logic [15:0] q;
    logic        ok;
    acvc_cpu_model_inst.xfer(1'b1, a[7:0], 16'h0000, q, ok);
    chk(16'(ok), 16'h0001);
    chk(q, (a < 10) ? mdl[a] : 16'h0000);
  endtask
  // Every conversion uses the shortest clock and resolution codes.
  task automatic conv(input logic [15:0] c, input int s);
    int          n, r;
    logic [15:0] ca, cb, v;
    logic        fx;
    r = 1 + 3 * s;
    ca = mdl[r + 1];
    cb = mdl[r + 2];
    fx = (c[11:8] >= SEL_FIXED_LO) && (c[11:8] <= SEL_FIXED_HI);
    seed = nxt(seed);
    v = seed;
    smp <= v;
    wr(0, c);
    for (n = 0; n < 10 && halt !== 1'b1; n++) @(posedge clk);
    #1;
    n = 0;
    while (halt === 1'b1 && n < 30000) begin
      n++;
      if (n == 2) begin
        chk(16'(conv_o), 16'h0001);
        chk(16'(src), 16'(s));
        chk(16'(sel), 16'(c[11:8]));
        chk(16'(gfix), 16'(fx));
        chk(16'(gain), 16'(fx ? GAIN_FIXED_LOW : ca[15:11]));
        chk(16'(resc), 16'(ca[6:4]));
        chk(16'(coff), 16'(ca[3:0]));
        chk({11'h000, bias, refs}, {11'h000, cb[6:4], cb[1:0]});
      end
      @(posedge clk);
      #1;
    end
    chk(n[15:0], 16'(256 * BASE_DIV * DEV_TICK));
    mdl[r] = v;
    mdl[0] = mdl[0] & 16'hFFF8;
    rd(0);
    for (n = 1; n < 10; n += 3) rd(n);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    resetn = 1'b0;
    smp = 16'h0000;
    seed = 16'h004E;
    for (int a = 0; a < 10; a++) begin
      mdl[a] = (a % 3 == 0 && a > 0) ? RST_SETB : RST_ZERO;
    end
    repeat (2) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    for (int a = 0; a < 11; a++) rd(a);
    wr(0, 16'hFFF8);
    for (int a = 1; a < 10; a++) begin
      seed = nxt(seed);
      wr(a, (a % 3 == 2) ? (seed & 16'hF88F) : seed);
    end
    for (int a = 0; a < 10; a++) rd(a);
    conv(16'h0007, 0);
    conv(16'h0402, 1);
    conv(16'h0001, 2);
    wr(0, 16'h0101);
    repeat (5) @(posedge clk);
    #1;
    chk(16'(halt), 16'h0000);
    mdl[0] = 16'h0100;
    rd(0);
    summarize();
  end
endmodule
